// ---- rtl/host_bus_dual_cs_read_timing.v ----
// Read strobe and chip-select sequencing of the host-bus memory interface
// How it works
// [RL1] With select field 2 (dual chip select) and continuous read, the first read asserts the other region's select with the strobe.
// [RL2] That wrong select drops at the next interface clock edge, where the addressed region's select rises.
// [RL3] The strobe stays asserted across the swap and its length counts from its first assertion.
// [RL4] Wait-state field 0 gives a two-clock strobe, one clock wrong select and one clock right select.
// [RL5] Further reads while output enable stays asserted assert only the addressed select.
// [RL6] Wait-state field 2 gives a six-clock strobe.
// [RL7] Software programs the wait-state one step above the peripheral's need to cover the lost clock.
// [RL8] Select field 0 is address-latch mode and 1 is single chip-select mode, beside the dual modes.
// [RL9] In every other configuration only the addressed select is asserted for the whole strobe.
`timescale 1ns/1ps
`include "host_bus_read_defs.vh"
module host_bus_dual_cs_read_timing
#(
  parameter [7:0] CLK_DIV = `CLK_DIV_DEFAULT
)
(
  input  wire       clock_in,
  input  wire       rst_n_in,
  input  wire [1:0] chip_select_config_field_in,
  input  wire [1:0] mode_field_in,
  input  wire [1:0] read_wait_state_field_in,
  input  wire       read_req_in,
  input  wire       region_sel_in,
  input  wire       read_end_in,
  output reg        read_ack_out,
  output reg        chip_select_zero_low_out,
  output reg        chip_select_one_low_out,
  output reg        read_strobe_low_out,
  output reg        output_enable_low_out,
  output reg        address_latch_out
);
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_STROBE = 2'h1;
  localparam [1:0] ST_DONE   = 2'h2;

  // Registered state of the read sequence
  reg  [1:0] state_ff;
  reg  [3:0] count_ff;
  reg        region_ff;
  reg        wrong_ff;
  reg        oe_held_ff;

  // Next values; they only take effect on an interface clock tick
  reg  [1:0] nxt_state;
  reg  [3:0] nxt_count;
  reg        nxt_region;
  reg        nxt_wrong;
  reg        nxt_oe_held;
  reg        nxt_ack;
  reg        nxt_latch;
  reg        nxt_cs_zero_low;
  reg        nxt_cs_one_low;
  reg        nxt_strobe_low;
  reg        nxt_oe_low;

  wire       tick;
  wire       dual_cs;
  wire       latch_mode;
  wire       dual_cont;
  wire       first_wrong;
  wire       last_clk;
  wire       target;

  host_bus_clk_div u_div
  (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .div_in   (CLK_DIV),
    .tick_out (tick)
  );

  // Strobe width in interface clocks: 0->2, 1->4, 2->6, 3->8
  function [3:0] strobe_clks;
    input [1:0] ws;
    begin
      strobe_clks = `STROBE_BASE_CLKS + {2'h0, ws} * `STROBE_STEP_CLKS; // RL4 RL6
    end
  endfunction

  // Active-low select of one region: low only when that region is the target
  function sel_low;
    input region;
    input target_region;
    begin
      sel_low = (region != target_region);
    end
  endfunction

  // Dual select encodings are 2 and 3; 0 and 1 drive one select only
  assign dual_cs     = (chip_select_config_field_in == `SEL_CFG_DUAL) ||
                       (chip_select_config_field_in == `SEL_CFG_LATCH_DUAL); // RL8
  assign latch_mode  = (chip_select_config_field_in == `SEL_CFG_ADDR_LATCH) ||
                       (chip_select_config_field_in == `SEL_CFG_LATCH_DUAL); // RL8
  assign dual_cont   = (chip_select_config_field_in == `SEL_CFG_DUAL) &&
                       (mode_field_in == `MODE_CONT_READ); // RL1
  // Output enable still low means the read continues a burst and is not the first
  assign first_wrong = dual_cont && !oe_held_ff; // RL1 RL5
  // Single select modes ignore the region bit: select zero is the device
  assign target      = dual_cs ? region_sel_in : 1'b0; // RL9
  assign last_clk    = (count_ff == `STROBE_CNT_ONE);

  always @*
  begin
    nxt_state       = state_ff;
    nxt_count       = count_ff;
    nxt_region      = region_ff;
    nxt_wrong       = wrong_ff;
    nxt_oe_held     = oe_held_ff;
    nxt_ack         = 1'b0;
    nxt_latch       = 1'b0;
    nxt_cs_zero_low = chip_select_zero_low_out;
    nxt_cs_one_low  = chip_select_one_low_out;
    nxt_strobe_low  = read_strobe_low_out;
    nxt_oe_low      = output_enable_low_out;
    case (state_ff)
      ST_IDLE:
      begin
        if (read_req_in)
        begin
          nxt_region     = target;
          nxt_count      = strobe_clks(read_wait_state_field_in); // RL4 RL6
          nxt_wrong      = first_wrong; // RL1
          nxt_strobe_low = 1'b0; // RL3
          nxt_oe_low     = 1'b0;
          nxt_oe_held    = 1'b1; // RL5
          nxt_latch      = latch_mode; // RL8
          if (first_wrong)
          begin
            // The other region's select goes out first, together with the strobe
            nxt_cs_zero_low = sel_low(1'b0, !target); // RL1
            nxt_cs_one_low  = sel_low(1'b1, !target); // RL1
          end
          else
          begin
            nxt_cs_zero_low = sel_low(1'b0, target); // RL5 RL9
            nxt_cs_one_low  = sel_low(1'b1, target); // RL5 RL9
          end
          nxt_state = ST_STROBE;
        end
        else if (read_end_in)
        begin
          nxt_oe_low  = 1'b1;
          nxt_oe_held = 1'b0;
        end
      end
      ST_STROBE:
      begin
        // Swap on the first tick; the strobe keeps counting through it
        if (wrong_ff)
        begin
          nxt_wrong       = 1'b0;
          nxt_cs_zero_low = sel_low(1'b0, region_ff); // RL2
          nxt_cs_one_low  = sel_low(1'b1, region_ff); // RL2
        end
        if (last_clk)
        begin
          nxt_strobe_low  = 1'b1; // RL3
          nxt_cs_zero_low = 1'b1;
          nxt_cs_one_low  = 1'b1;
          nxt_ack         = 1'b1;
          nxt_state       = ST_DONE;
        end
        else
        begin
          nxt_count = count_ff - `STROBE_CNT_ONE; // RL3
        end
      end
      ST_DONE:
      begin
        // A burst may end here or stay open for the next read
        if (read_end_in)
        begin
          nxt_oe_low  = 1'b1;
          nxt_oe_held = 1'b0;
        end
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      // Bus idles with every strobe and select released
      state_ff                 <= ST_IDLE;
      count_ff                 <= `STROBE_CNT_ZERO;
      region_ff                <= 1'b0;
      wrong_ff                 <= 1'b0;
      oe_held_ff               <= 1'b0;
      read_ack_out             <= 1'b0;
      chip_select_zero_low_out <= 1'b1;
      chip_select_one_low_out  <= 1'b1;
      read_strobe_low_out      <= 1'b1;
      output_enable_low_out    <= 1'b1;
      address_latch_out        <= 1'b0;
    end
    else if (tick)
    begin
      // Everything on the bus moves on the interface clock only
      state_ff                 <= nxt_state;
      count_ff                 <= nxt_count;
      region_ff                <= nxt_region;
      wrong_ff                 <= nxt_wrong;
      oe_held_ff               <= nxt_oe_held;
      read_ack_out             <= nxt_ack;
      chip_select_zero_low_out <= nxt_cs_zero_low;
      chip_select_one_low_out  <= nxt_cs_one_low;
      read_strobe_low_out      <= nxt_strobe_low;
      output_enable_low_out    <= nxt_oe_low;
      address_latch_out        <= nxt_latch;
    end
    else
    begin
      // Ack stays one system clock wide when the interface clock is slower
      read_ack_out <= 1'b0;
    end
  end
endmodule // host_bus_dual_cs_read_timing

// ---- rtl/host_bus_read_defs.vh ----
// Constants for the host-bus read chip-select sequencer
`ifndef HOST_BUS_READ_DEFS_VH
`define HOST_BUS_READ_DEFS_VH
`define SEL_CFG_ADDR_LATCH 2'h0
`define SEL_CFG_SINGLE     2'h1
`define SEL_CFG_DUAL       2'h2
`define SEL_CFG_LATCH_DUAL 2'h3
`define MODE_CONT_READ    2'h2
`define STROBE_BASE_CLKS  4'h2
`define STROBE_STEP_CLKS  4'h2
`define STROBE_CNT_ONE    4'h1
`define STROBE_CNT_ZERO   4'h0
`define CLK_DIV_DEFAULT   8'h01
`define CLK_CNT_ZERO      8'h00
`define CLK_CNT_ONE       8'h01
`endif

// ---- rtl/host_bus_clk_div.v ----
// Interface clock enable divider
`timescale 1ns/1ps
module host_bus_clk_div
(
  input  wire       clock_in,
  input  wire       rst_n_in,
  input  wire [7:0] div_in,
  output reg        tick_out
);
  `include "host_bus_read_defs.vh"
  reg  [7:0] cnt_ff;
  wire [7:0] nxt_cnt;
  // Divide of zero ticks on every clock so the strobe timing never stalls
  assign nxt_cnt = (cnt_ff >= div_in || div_in == `CLK_CNT_ZERO) ? `CLK_CNT_ZERO : cnt_ff + `CLK_CNT_ONE;
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      cnt_ff   <= `CLK_CNT_ZERO;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      tick_out <= (nxt_cnt == `CLK_CNT_ZERO);
    end
  end
endmodule // host_bus_clk_div

// ---- tb/hb_chk_checker.sv ----
// Checker for the host-bus read select sequencer
`timescale 1ns/1ps
module hb_chk (
  input wire       clock_in,
  input wire       rst_n_in,
  input wire [1:0] chip_select_config_field_in,
  input wire [1:0] mode_field_in,
  input wire [1:0] read_wait_state_field_in,
  input wire       region_sel_in,
  input wire       read_ack_out,
  input wire       chip_select_zero_low_out,
  input wire       chip_select_one_low_out,
  input wire       read_strobe_low_out,
  input wire       output_enable_low_out,
  input wire       address_latch_out
);
  wire       s  = read_strobe_low_out;
  wire       c0 = chip_select_zero_low_out;
  wire       c1 = chip_select_one_low_out;
  wire [1:0] ws = read_wait_state_field_in;
  wire       oe = output_enable_low_out;
  wire       dc = chip_select_config_field_in == 2'h2 && mode_field_in == 2'h2;
  // Select fields 0 and 1 (address-latch and single) always use select zero
  wire       ok = chip_select_config_field_in[1] && region_sel_in ? !c1 : !c0;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sel_excl_a: assert property (c0 || c1) else $error("two selects");
  sel_idle_a: assert property ((c0 && c1) == s) else $error("select vs strobe");
  ack_end_a: assert property (read_ack_out == $rose(s)) else $error("ack");
  ws_zero_a: assert property ($fell(s) && ws == 2'h0 |-> !s [*2] ##1 s) else $error("ws0");
  ws_two_a: assert property ($fell(s) && ws == 2'h2 |-> !s [*6] ##1 s) else $error("ws2");
  first_wrong_a: assert property ($fell(s) && dc && $past(oe) |-> !ok) else $error("first");
  first_addr_a: assert property ($fell(s) && !(dc && $past(oe)) |-> ok) else $error("addr");
  swap_right_a: assert property (!s && !$past(s) |-> ok) else $error("swap");
  latch_start_a: assert property ($fell(s) |-> address_latch_out == (chip_select_config_field_in == 2'h0 ||
    chip_select_config_field_in == 2'h3)) else $error("latch");
  cover property ($fell(s) && dc && $past(oe));
  cover property ($fell(s) && ws == 2'h3);
  cover property (read_ack_out && !oe);
endmodule // hb_chk
bind host_bus_dual_cs_read_timing hb_chk u_chk (.*);

// ---- tb/hb_mem.sv ----
// Memory-side model: measures each strobe and its select-zero cycles
`timescale 1ns/1ps
module hb_mem (
  input wire       clock_in,
  input wire       strobe_low_in,
  input wire       cs_zero_low_in,
  input wire       latch_in,
  output reg [3:0] width_out,
  output reg [3:0] zero_out,
  output reg       latch_out
);
  reg prev_ff = 1'b1;
  always @(posedge clock_in)
  begin
    prev_ff <= strobe_low_in;
    if (!strobe_low_in)
    begin
      width_out <= prev_ff ? 4'h1 : width_out + 4'h1;
      zero_out  <= (prev_ff ? 4'h0 : zero_out) + {3'h0, !cs_zero_low_in};
      // Address is taken from the bus at the first strobe cycle only
      if (prev_ff)
        latch_out <= latch_in;
    end
  end
endmodule // hb_mem

// ---- tb/tb_top.sv ----
// Random and corner read bursts through the select sequencer
`timescale 1ns/1ps
module tb_top;
  reg clock_in = 1'b0, rst_n_in = 1'b0, req = 1'b0, rg = 1'b0, rend = 1'b0, f;
  reg [1:0] cfg = 2'h0, mode = 2'h2, ws = 2'h0;
  wire ack, c0, c1, s, oe, al, la;
  wire [3:0] w, z;
  integer num_errors = 0, n_compared = 0, i, j, k;
  always #4 clock_in = ~clock_in;
  host_bus_dual_cs_read_timing #(.CLK_DIV(8'h00)) u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .chip_select_config_field_in(cfg), .mode_field_in(mode), .read_wait_state_field_in(ws),
    .read_req_in(req), .region_sel_in(rg), .read_end_in(rend), .read_ack_out(ack),
    .chip_select_zero_low_out(c0), .chip_select_one_low_out(c1), .read_strobe_low_out(s),
    .output_enable_low_out(oe), .address_latch_out(al));
  hb_mem u_mem (.clock_in(clock_in), .strobe_low_in(s), .cs_zero_low_in(c0), .latch_in(al), .width_out(w),
    .zero_out(z), .latch_out(la));
  function [3:0] exp_width(input [1:0] w_s);
    exp_width = 4'h2 + {1'b0, w_s, 1'b0};
  endfunction
  function [3:0] exp_zero(input [1:0] cf, input r, input first, input [1:0] w_s);
    exp_zero = (cf[1] && r) ? {3'h0, first} : exp_width(w_s) - {3'h0, first};
  endfunction
  function exp_latch(input [1:0] cf);
    exp_latch = (cf == 2'h0) || (cf == 2'h3);
  endfunction
  task chk(input [39:0] nm, input [7:0] e, input [7:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("wrong value %0s expected %0d seen %0d", nm, e, g);
    end
  end
  endtask
  task rd;
  begin
    @(posedge clock_in);
    k = $urandom;
    rg <= k[0];
    req <= 1'b1;
    for (k = 0; k < 40 && ack !== 1'b1; k = k + 1) @(posedge clock_in);
    req <= 1'b0;
    // Taken one edge after the request, ack seen one edge after the strobe ends
    chk("ack", {4'h0, exp_width(ws)} + 8'h02, k[7:0]);
    repeat (2) @(posedge clock_in);
    f = f && cfg == 2'h2 && mode == 2'h2;
    chk("width", exp_width(ws), w);
    chk("zero", exp_zero(cfg, rg, f, ws), z);
    chk("latch", exp_latch(cfg), la);
    chk("oe", 8'h00, oe);
    f = 1'b0;
  end
  endtask
  task results;
  begin
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    k = $urandom(59);
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (i = 0; i < 16; i = i + 1)
    begin
      cfg <= i[1:0];
      mode <= i < 8 ? 2'h2 : 2'($urandom);
      // Corner widths first: the two-clock and six-clock strobes
      ws <= i < 4 ? 2'h0 : i < 8 ? 2'h2 : 2'($urandom);
      f = 1'b1;
      for (j = 0; j < 3; j = j + 1) rd;
      rend <= 1'b1;
      repeat (3) @(posedge clock_in);
      rend <= 1'b0;
      chk("oe", 8'h01, oe);
      $display("test %0d done", i);
    end
    results;
  end
  initial
  begin
    #200000;
    num_errors = num_errors + 1;
    results;
  end
endmodule // tb_top
